// ===== fpc_clock_control.v
`timescale 1ns/100ps
`include "fpc_defs.vh"

module fpc_clock_control #(
    parameter ADDR_W  = 8,
    parameter ACC_W   = 32
) (
    // Clock and reset
    input  wire              aclk,
    input  wire              aresetn,
    // Write address channel
    input  wire [ADDR_W-1:0] s_axi_awaddr,
    input  wire              s_axi_awvalid,
    output reg               s_axi_awready,
    // Write data channel
    input  wire [31:0]       s_axi_wdata,
    input  wire [3:0]        s_axi_wstrb,
    input  wire              s_axi_wvalid,
    output reg               s_axi_wready,
    // Write response channel
    output reg  [1:0]        s_axi_bresp,
    output reg               s_axi_bvalid,
    input  wire              s_axi_bready,
    // Read address channel
    input  wire [ADDR_W-1:0] s_axi_araddr,
    input  wire              s_axi_arvalid,
    output reg               s_axi_arready,
    // Read data channel
    output reg  [31:0]       s_axi_rdata,
    output reg  [1:0]        s_axi_rresp,
    output reg               s_axi_rvalid,
    input  wire              s_axi_rready,
    // Reference clock pin
    input  wire              master_clock_in,
    // System clock outputs
    output reg               system_clock_tick_q,
    output reg               system_clock_q,
    output reg               synth_active_q,
    // Shared select/gpio pin, output side
    output reg               select_or_gpio_pin_out_q,
    output reg               select_or_gpio_pin_oe_n_q
);

    // Register storage
    reg  [8:0]       pwr_mgmt_one_q;
    reg  [8:0]       clock_gen_q;
    reg  [8:0]       gpio_ctrl_q;
    reg  [8:0]       synth_integer_q;
    reg  [8:0]       synth_frac_high_q;
    reg  [8:0]       synth_frac_mid_q;
    reg  [8:0]       synth_frac_low_q;

    // Reference synchroniser and prescaler
    reg              mclk_s1_q;
    reg              mclk_s2_q;
    reg              mclk_s3_q;
    reg  [1:0]       pre_cnt_q;
    reg              ref_tick_d;

    // Synthesizer model and dividers
    reg  [ACC_W-1:0] credit_q;
    reg  [ACC_W-1:0] credit_d;
    reg              synth_pulse_q;
    reg  [1:0]       post4_cnt_q;
    reg              post4_tick_d;
    reg  [4:0]       sys_acc_q;
    reg  [4:0]       sys_acc_d;
    reg              sys_tick_d;
    reg              src_sel_q;
    reg  [4:0]       div_half_q;
    reg  [4:0]       div_half_new;
    reg  [1:0]       op_cnt_q;

    // Bus helpers
    wire [31:0]      wr_addr_ext;
    wire [31:0]      rd_addr_ext;
    wire [6:0]       wr_idx;
    wire [6:0]       rd_idx;
    wire             wr_fire;
    wire             rd_fire;
    reg              wr_hit;
    reg              rd_hit;
    reg  [8:0]       rd_val;
    reg  [8:0]       wr_mask;

    // Derived control
    wire             synth_run;
    wire [1:0]       prescale;
    wire [27:0]      ratio;
    wire [23:0]      fraction;

    // Synthesizer runs only with enable, nonzero midrail and power on
    assign synth_run = pwr_mgmt_one_q[`FPC_SYNTH_ENABLE_BIT]
                     & (pwr_mgmt_one_q[`FPC_MIDRAIL_MSB:`FPC_MIDRAIL_LSB] != 2'h0)
                     & ~synth_integer_q[`FPC_POWER_OFF_BIT];
    assign prescale  = synth_integer_q[`FPC_PRESCALE_MSB:`FPC_PRESCALE_LSB];

    // Fraction joined from three registers
    assign fraction  = {synth_frac_high_q[`FPC_FRAC_HIGH_MSB:0],
                        synth_frac_mid_q, synth_frac_low_q};
    // Ratio in fixed point, fraction ignored when disabled
    assign ratio     = {synth_integer_q[`FPC_INTEGER_MSB:`FPC_INTEGER_LSB],
                        synth_integer_q[`FPC_FRAC_ENABLE_BIT] ? fraction : 24'h000000};

    // Bus address decode, word aligned
    assign wr_addr_ext = {{(32-ADDR_W){1'b0}}, s_axi_awaddr};
    assign rd_addr_ext = {{(32-ADDR_W){1'b0}}, s_axi_araddr};
    assign wr_idx  = wr_addr_ext[8:2];
    assign rd_idx  = rd_addr_ext[8:2];
    assign wr_fire = s_axi_awvalid & s_axi_wvalid & ~s_axi_awready & ~s_axi_bvalid;
    assign rd_fire = s_axi_arvalid & ~s_axi_arready & ~s_axi_rvalid;

    // Write hit check and byte lane mask
    always @* begin
        wr_mask = {s_axi_wstrb[1], {8{s_axi_wstrb[0]}}};
        case (wr_idx)
            `FPC_IDX_PWR_MGMT_ONE, `FPC_IDX_CLOCK_GEN, `FPC_IDX_GPIO_CTRL,
            `FPC_IDX_SYNTH_INTEGER, `FPC_IDX_SYNTH_FRAC_HIGH,
            `FPC_IDX_SYNTH_FRAC_MID, `FPC_IDX_SYNTH_FRAC_LOW: wr_hit = 1'b1;
            default: wr_hit = 1'b0;
        endcase
        if (wr_addr_ext[31:9] != 23'h0) begin
            wr_hit = 1'b0;
        end
    end

    // Read mux, status shows live block state
    always @* begin
        rd_hit = 1'b1;
        case (rd_idx)
            `FPC_IDX_PWR_MGMT_ONE:    rd_val = pwr_mgmt_one_q;
            `FPC_IDX_CLOCK_GEN:       rd_val = clock_gen_q;
            `FPC_IDX_GPIO_CTRL:       rd_val = gpio_ctrl_q;
            `FPC_IDX_SYNTH_INTEGER:   rd_val = synth_integer_q;
            `FPC_IDX_SYNTH_FRAC_HIGH: rd_val = {3'h0, synth_frac_high_q[`FPC_FRAC_HIGH_MSB:0]};
            `FPC_IDX_SYNTH_FRAC_MID:  rd_val = synth_frac_mid_q;
            `FPC_IDX_SYNTH_FRAC_LOW:  rd_val = synth_frac_low_q;
            `FPC_IDX_STATUS:          rd_val = {4'h0, system_clock_q, src_sel_q,
                                                select_or_gpio_pin_out_q, synth_pulse_q, synth_active_q};
            default: begin
                rd_val = 9'h000;
                rd_hit = 1'b0;
            end
        endcase
        if (rd_addr_ext[31:9] != 23'h0) begin
            rd_hit = 1'b0;
        end
    end

    // Write channel: take address and data together, answer next cycle
    always @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_awready     <= 1'b0;
            s_axi_wready      <= 1'b0;
            s_axi_bvalid      <= 1'b0;
            s_axi_bresp       <= `FPC_RESP_OKAY;
            pwr_mgmt_one_q    <= `FPC_RST_PWR_MGMT_ONE;
            clock_gen_q       <= `FPC_RST_CLOCK_GEN;
            gpio_ctrl_q       <= `FPC_RST_GPIO_CTRL;
            synth_integer_q   <= `FPC_RST_SYNTH_INTEGER;
            synth_frac_high_q <= `FPC_RST_SYNTH_FRAC_HIGH;
            synth_frac_mid_q  <= `FPC_RST_SYNTH_FRAC_MID;
            synth_frac_low_q  <= `FPC_RST_SYNTH_FRAC_LOW;
        end else begin
            s_axi_awready <= wr_fire;
            s_axi_wready  <= wr_fire;
            if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end else if (wr_fire) begin
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= wr_hit ? `FPC_RESP_OKAY : `FPC_RESP_SLVERR;
            end
            if (wr_fire && wr_hit) begin
                case (wr_idx)
                    `FPC_IDX_PWR_MGMT_ONE:
                        pwr_mgmt_one_q <= (pwr_mgmt_one_q & ~wr_mask) | (s_axi_wdata[8:0] & wr_mask);
                    `FPC_IDX_CLOCK_GEN:
                        clock_gen_q <= (clock_gen_q & ~wr_mask) | (s_axi_wdata[8:0] & wr_mask);
                    `FPC_IDX_GPIO_CTRL:
                        gpio_ctrl_q <= (gpio_ctrl_q & ~wr_mask) | (s_axi_wdata[8:0] & wr_mask);
                    `FPC_IDX_SYNTH_INTEGER:
                        synth_integer_q <= (synth_integer_q & ~wr_mask) | (s_axi_wdata[8:0] & wr_mask);
                    `FPC_IDX_SYNTH_FRAC_HIGH:
                        synth_frac_high_q <= (synth_frac_high_q & ~wr_mask) | (s_axi_wdata[8:0] & wr_mask);
                    `FPC_IDX_SYNTH_FRAC_MID:
                        synth_frac_mid_q <= (synth_frac_mid_q & ~wr_mask) | (s_axi_wdata[8:0] & wr_mask);
                    `FPC_IDX_SYNTH_FRAC_LOW:
                        synth_frac_low_q <= (synth_frac_low_q & ~wr_mask) | (s_axi_wdata[8:0] & wr_mask);
                    default: ;
                endcase
            end
        end
    end

    // Read channel: one cycle to data
    always @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= 32'h00000000;
            s_axi_rresp   <= `FPC_RESP_OKAY;
        end else begin
            s_axi_arready <= rd_fire;
            if (s_axi_rvalid && s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end else if (rd_fire) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rdata  <= {23'h0, rd_val};
                s_axi_rresp  <= rd_hit ? `FPC_RESP_OKAY : `FPC_RESP_SLVERR;
            end
        end
    end

    // Reference pin synchroniser, third stage for edge detect
    always @(posedge aclk) begin
        if (!aresetn) begin
            mclk_s1_q <= 1'b0;
            mclk_s2_q <= 1'b0;
            mclk_s3_q <= 1'b0;
        end else begin
            mclk_s1_q <= master_clock_in;
            mclk_s2_q <= mclk_s1_q;
            mclk_s3_q <= mclk_s2_q;
        end
    end

    // Prescaled reference tick
    always @* begin
        case (prescale)
            2'h0:    ref_tick_d = mclk_s2_q ^ mclk_s3_q;
            2'h1:    ref_tick_d = mclk_s2_q & ~mclk_s3_q;
            2'h2:    ref_tick_d = mclk_s2_q & ~mclk_s3_q & pre_cnt_q[0];
            default: ref_tick_d = mclk_s2_q & ~mclk_s3_q & (pre_cnt_q == 2'h3);
        endcase
    end

    // Rising edge counter for divide by two and four
    always @(posedge aclk) begin
        if (!aresetn) begin
            pre_cnt_q <= 2'h0;
        end else if (mclk_s2_q && !mclk_s3_q) begin
            pre_cnt_q <= pre_cnt_q + 2'h1;
        end
    end

    // Credit model: each reference tick earns ratio output pulses
    always @* begin
        credit_d = credit_q;
        if (ref_tick_d) begin
            credit_d = credit_d + {{(ACC_W-28){1'b0}}, ratio};
        end
        if (credit_q[ACC_W-1:`FPC_FRAC_BITS] != {(ACC_W-24){1'b0}}) begin
            credit_d = credit_d - {{(ACC_W-25){1'b0}}, 1'b1, 24'h000000};
        end
    end

    // Synthesizer output pulses, cleared while stopped
    always @(posedge aclk) begin
        if (!aresetn) begin
            credit_q       <= {ACC_W{1'b0}};
            synth_pulse_q  <= 1'b0;
            synth_active_q <= 1'b0;
        end else begin
            synth_active_q <= synth_run;
            if (synth_run) begin
                credit_q      <= credit_d;
                synth_pulse_q <= credit_q[ACC_W-1:`FPC_FRAC_BITS] != {(ACC_W-24){1'b0}};
            end else begin
                credit_q      <= {ACC_W{1'b0}};
                synth_pulse_q <= 1'b0;
            end
        end
    end

    // Fixed divide by four of synthesizer pulses
    always @* begin
        post4_tick_d = synth_pulse_q && (post4_cnt_q == (`FPC_FIXED_POST_DIV - 3'h1));
    end

    always @(posedge aclk) begin
        if (!aresetn) begin
            post4_cnt_q <= 2'h0;
        end else if (synth_pulse_q) begin
            post4_cnt_q <= post4_cnt_q + 2'h1;
        end
    end

    // Divider code to half steps
    always @* begin
        case (clock_gen_q[`FPC_SYSDIV_MSB:`FPC_SYSDIV_LSB])
            3'h0:    div_half_new = 5'h02;
            3'h1:    div_half_new = 5'h03;
            3'h2:    div_half_new = 5'h04;
            3'h3:    div_half_new = 5'h06;
            3'h4:    div_half_new = 5'h08;
            3'h5:    div_half_new = 5'h0C;
            3'h6:    div_half_new = 5'h10;
            default: div_half_new = 5'h18;
        endcase
    end

    // System divider: two half steps per input tick
    always @* begin
        sys_tick_d = 1'b0;
        sys_acc_d  = sys_acc_q;
        if (src_sel_q ? post4_tick_d : (mclk_s2_q && !mclk_s3_q)) begin
            if (sys_acc_q + 5'h02 >= div_half_q) begin
                sys_acc_d  = sys_acc_q + 5'h02 - div_half_q;
                sys_tick_d = 1'b1;
            end else begin
                sys_acc_d  = sys_acc_q + 5'h02;
            end
        end
    end

    // Remainder kept across ticks; settings applied only when it is empty
    always @(posedge aclk) begin
        if (!aresetn) begin
            sys_acc_q           <= 5'h00;
            src_sel_q           <= 1'b1;
            div_half_q          <= 5'h04;
            system_clock_tick_q <= 1'b0;
            system_clock_q      <= 1'b0;
        end else begin
            system_clock_tick_q <= sys_tick_d;
            if (sys_tick_d) begin
                system_clock_q <= ~system_clock_q;
            end
            sys_acc_q <= sys_acc_d;
            if (sys_acc_d == 5'h00) begin
                src_sel_q  <= clock_gen_q[`FPC_CORE_SOURCE_BIT];
                div_half_q <= div_half_new;
            end
        end
    end

    // Output pin clock: divided post-four synthesizer clock
    always @(posedge aclk) begin
        if (!aresetn) begin
            op_cnt_q                  <= 2'h0;
            select_or_gpio_pin_out_q  <= 1'b0;
            select_or_gpio_pin_oe_n_q <= 1'b1;
        end else begin
            select_or_gpio_pin_oe_n_q <= gpio_ctrl_q[`FPC_PINSEL_MSB:`FPC_PINSEL_LSB]
                                         != `FPC_PINSEL_CLOCK_OUT;
            if (post4_tick_d) begin
                if (op_cnt_q >= gpio_ctrl_q[`FPC_OUTPUT_CLOCK_DIVIDER_MSB:`FPC_OUTPUT_CLOCK_DIVIDER_LSB]) begin
                    op_cnt_q                 <= 2'h0;
                    select_or_gpio_pin_out_q <= ~select_or_gpio_pin_out_q;
                end else begin
                    op_cnt_q <= op_cnt_q + 2'h1;
                end
            end
        end
    end

endmodule // fpc_clock_control

// ===== fpc_defs.vh
// Notes on behaviour
// - Synthesizer runs when its enable bit is 1 and the power-off bit is 0, stops when enable is 0.
// - Midrail select field equal to zero forces the synthesizer off.
// - Ratio equals integer field plus fraction field over two to 24.
// - Synthesizer output divided by four, then by system clock divider.
// - Fraction enable resets to 1; when clear the fraction is ignored.
// - Prescale 00 doubles, 01 passes, 10 halves, 11 quarters the reference.
// - Fraction bits come from three registers, joined as one number.
// - A synthesizer-derived clock can be driven on the shared select pin.
// - Core clock source bit resets to 1: divided synthesizer, else raw reference.
// - System divider codes divide by 1,1.5,2,3,4,6,8,12; reset 010.
// - Output divider codes divide the pin clock by 1,2,3,4.
`ifndef FPC_DEFS_VH
`define FPC_DEFS_VH

// Register indices; byte address is four times the index
`define FPC_IDX_PWR_MGMT_ONE     7'h01
`define FPC_IDX_CLOCK_GEN        7'h06
`define FPC_IDX_GPIO_CTRL        7'h08
`define FPC_IDX_SYNTH_INTEGER    7'h24
`define FPC_IDX_SYNTH_FRAC_HIGH  7'h25
`define FPC_IDX_SYNTH_FRAC_MID   7'h26
`define FPC_IDX_SYNTH_FRAC_LOW   7'h27
`define FPC_IDX_STATUS           7'h30

// Reset values
`define FPC_RST_PWR_MGMT_ONE     9'h000
`define FPC_RST_CLOCK_GEN        9'h140
`define FPC_RST_GPIO_CTRL        9'h000
`define FPC_RST_SYNTH_INTEGER    9'h04C
`define FPC_RST_SYNTH_FRAC_HIGH  9'h00C
`define FPC_RST_SYNTH_FRAC_MID   9'h093
`define FPC_RST_SYNTH_FRAC_LOW   9'h0E9

// Field positions
`define FPC_MIDRAIL_MSB          1
`define FPC_MIDRAIL_LSB          0
`define FPC_SYNTH_ENABLE_BIT     5
`define FPC_CORE_SOURCE_BIT      8
`define FPC_SYSDIV_MSB           7
`define FPC_SYSDIV_LSB           5
`define FPC_OUTPUT_CLOCK_DIVIDER_MSB         5
`define FPC_OUTPUT_CLOCK_DIVIDER_LSB         4
`define FPC_PINSEL_MSB           2
`define FPC_PINSEL_LSB           0
`define FPC_PINSEL_CLOCK_OUT     3'h4
`define FPC_POWER_OFF_BIT        7
`define FPC_FRAC_ENABLE_BIT      6
`define FPC_PRESCALE_MSB         5
`define FPC_PRESCALE_LSB         4
`define FPC_INTEGER_MSB          3
`define FPC_INTEGER_LSB          0
`define FPC_FRAC_HIGH_MSB        5

// Timing and arithmetic constants
`define FPC_FRAC_BITS            24
`define FPC_FIXED_POST_DIV       3'h4
`define FPC_RESP_OKAY            2'h0
`define FPC_RESP_SLVERR          2'h2

`endif

// ===== fpc_clock_control_properties.sv
`timescale 1ns/100ps
module fpc_clock_control_checker (
    // Clock and reset
    input wire        aclk,
    input wire        aresetn,
    // Register bus handshakes
    input wire        s_axi_awvalid,
    input wire        s_axi_wvalid,
    input wire        s_axi_awready,
    input wire        s_axi_wready,
    input wire        s_axi_bvalid,
    input wire        s_axi_bready,
    input wire [1:0]  s_axi_bresp,
    input wire        s_axi_arvalid,
    input wire        s_axi_arready,
    input wire        s_axi_rvalid,
    input wire        s_axi_rready,
    input wire [31:0] s_axi_rdata,
    // Clock outputs
    input wire        system_clock_tick_q,
    input wire        system_clock_q,
    input wire        synth_active_q,
    input wire        select_or_gpio_pin_oe_n_q
);
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    // Requests the slave takes
    sequence s_write_taken;
        s_axi_awvalid && s_axi_wvalid && !s_axi_awready && !s_axi_bvalid;
    endsequence
    sequence s_read_taken;
        s_axi_arvalid && !s_axi_arready && !s_axi_rvalid;
    endsequence
    sequence s_recent_write;
        s_axi_bvalid || $past(s_axi_bvalid) || $past(s_axi_bvalid, 2);
    endsequence

    // Bus answers and holds
    property p_write_answer;
        s_write_taken |=> s_axi_awready && s_axi_wready && s_axi_bvalid;
    endproperty
    a_write_answer: assert property (p_write_answer) else $error("write answer late");
    property p_bresp_hold;
        s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
    endproperty
    a_bresp_hold: assert property (p_bresp_hold) else $error("write response dropped");
    property p_read_answer;
        s_read_taken |=> s_axi_arready && s_axi_rvalid;
    endproperty
    a_read_answer: assert property (p_read_answer) else $error("read answer late");
    property p_rdata_hold;
        s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
    endproperty
    a_rdata_hold: assert property (p_rdata_hold) else $error("read data dropped");
    property p_rdata_width;
        s_axi_rvalid |-> s_axi_rdata[31:9] == 23'h0;
    endproperty
    a_rdata_width: assert property (p_rdata_width) else $error("read data above bit 8");

    // Clock path
    property p_tick_single;
        system_clock_tick_q |=> !system_clock_tick_q;
    endproperty
    a_tick_single: assert property (p_tick_single) else $error("tick wider than a cycle");
    property p_system_clock_on_tick;
        $changed(system_clock_q) |-> system_clock_tick_q || $past(system_clock_tick_q);
    endproperty
    a_system_clock_on_tick: assert property (p_system_clock_on_tick) else $error("system clock off tick");
    property p_active_by_write;
        $changed(synth_active_q) |-> s_recent_write;
    endproperty
    a_active_by_write: assert property (p_active_by_write) else $error("synth state moved alone");
    property p_oe_by_write;
        $changed(select_or_gpio_pin_oe_n_q) |-> s_recent_write;
    endproperty
    a_oe_by_write: assert property (p_oe_by_write) else $error("pin enable moved alone");
endmodule // fpc_clock_control_checker

bind fpc_clock_control fpc_clock_control_checker u_fpc_chk (
    .aclk(aclk), .aresetn(aresetn), .s_axi_awvalid(s_axi_awvalid), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_awready(s_axi_awready), .s_axi_wready(s_axi_wready), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_bresp(s_axi_bresp), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
    .s_axi_rdata(s_axi_rdata), .system_clock_tick_q(system_clock_tick_q), .system_clock_q(system_clock_q),
    .synth_active_q(synth_active_q), .select_or_gpio_pin_oe_n_q(select_or_gpio_pin_oe_n_q));

// ===== fpc_ref_source.sv
`timescale 1ns/100ps
module fpc_ref_source (
    // Half period in ns, from the bench
    input wire [15:0] half_ns,
    // Reference pin
    output reg        master_clock_in
);
    // Free-running reference, phase unrelated to aclk
    initial master_clock_in = 1'b0;
    always begin
        #(half_ns | 16'h1);
        master_clock_in = ~master_clock_in;
    end
endmodule // fpc_ref_source

// ===== fpc_testbench.sv
`timescale 1ns/100ps
module testbench;
    logic        aclk = 1'b0;
    logic        aresetn = 1'b0;
    logic [7:0]  awaddr = 8'h00;
    logic [7:0]  araddr = 8'h00;
    logic [31:0] wdata = 32'h0;
    logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    wire         awready, wready, bvalid, arready, rvalid, tick, pin, pin_oe_n, active, ref_clk, system_clock;
    wire  [1:0]  bresp, rresp;
    wire  [31:0] rdata;
    logic [15:0] ref_half = 16'd83;
    integer      failures = 0, checks = 0, seed = 32'h38F1;
    integer      n_tick, n_pin, n_clk, n_ref, i, j, n;
    logic [31:0] rd, wd;
    logic [1:0]  rs, pre, opd;
    logic [2:0]  dc;
    logic [23:0] k;
    logic        fen, src, on, win = 1'b0, pin_last = 1'b0, clk_last = 1'b0;
    real         post4, exp_t;
    logic [7:0]  addr_tab [7] = '{8'h04, 8'h18, 8'h20, 8'h90, 8'h94, 8'h98, 8'h9C};
    logic [8:0]  rst_tab [7] = '{9'h000, 9'h140, 9'h000, 9'h04C, 9'h00C, 9'h093, 9'h0E9};
    logic [8:0]  pm_tab [4] = '{9'h021, 9'h020, 9'h001, 9'h023};
    int          dx2 [8] = '{2, 3, 4, 6, 8, 12, 16, 24};

    always #2.5 aclk = ~aclk;

    fpc_clock_control dut (
        .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
        .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
        .s_axi_rvalid(rvalid), .s_axi_rready(rready), .master_clock_in(ref_clk), .system_clock_tick_q(tick),
        .system_clock_q(system_clock), .synth_active_q(active), .select_or_gpio_pin_out_q(pin),
        .select_or_gpio_pin_oe_n_q(pin_oe_n));
    fpc_ref_source u_ref (.half_ns(ref_half), .master_clock_in(ref_clk));

    // Counters for the measuring window
    always @(posedge aclk) begin
        if (win && tick === 1'b1) n_tick <= n_tick + 1;
        if (win && pin !== pin_last) n_pin <= n_pin + 1;
        pin_last <= pin;
        if (win && system_clock !== clk_last) n_clk <= n_clk + 1;
        clk_last <= system_clock;
    end
    always @(posedge ref_clk) if (win) n_ref = n_ref + 1;

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp, input integer tol);
        checks++;
        if (tol == 0 ? seen !== exp : (seen > exp + tol || seen + tol < exp)) begin
            failures++;
            $display("ERROR %s expected %0d seen %0d", what, exp, seen);
        end
    endtask

    // Write with both channels offered together, each dropped when taken
    task automatic axi_write(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
        integer c;
        @(posedge aclk);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        c = 0;
        do begin
            @(posedge aclk);
            if (awready === 1'b1) awvalid <= 1'b0;
            if (wready === 1'b1) wvalid <= 1'b0;
            c++;
        end while (bvalid !== 1'b1 && c < 100);
        r = bresp;
        bready <= 1'b0;
        if (c >= 100) failures++;
    endtask

    task automatic axi_read(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        integer c;
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        c = 0;
        do begin
            @(posedge aclk);
            if (arready === 1'b1) arvalid <= 1'b0;
            c++;
        end while (rvalid !== 1'b1 && c < 100);
        d = rdata;
        r = rresp;
        rready <= 1'b0;
        if (c >= 100) failures++;
    endtask

    task automatic give_verdict;
        $display("checks %0d failures %0d", checks, failures);
        if (failures == 0 && checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    // Watchdog against a hung bus
    initial begin
        #400000;
        failures++;
        give_verdict;
    end

    initial begin
        repeat (10) @(posedge aclk);
        aresetn <= 1'b1;
        for (i = 0; i < 7; i++) begin
            axi_read(addr_tab[i], rd, rs);
            check("reset value", rd, {23'h0, rst_tab[i]}, 0);
        end
        for (i = 4; i < 7; i++) begin
            wd = $random(seed) & 32'h1FF;
            axi_write(addr_tab[i], wd, rs);
            axi_read(addr_tab[i], rd, rs);
            check("readback", rd, (i == 4) ? (wd & 32'h3F) : wd, 0);
        end
        axi_write(8'h08, 32'h1FF, rs);
        check("unmapped write resp", {30'h0, rs}, 2, 0);
        axi_read(8'h08, rd, rs);
        check("unmapped read", {rd[29:0], rs}, 2, 0);
        // Enable, midrail and power-off combinations
        for (i = 0; i < 4; i++) begin
            axi_write(8'h90, {24'h0, i == 3, 7'h4C}, rs);
            axi_write(8'h04, {23'h0, pm_tab[i]}, rs);
            repeat (3) @(posedge aclk);
            axi_read(8'hC0, rd, rs);
            check("synth active", {31'h0, rd[0]}, i == 0, 0);
        end
        // Frequency cases: fixed walk, raw source, random, stopped
        for (j = 0; j < 9; j++) begin
            n = (j == 0) ? 8 : 5 + ($random(seed) & 7);
            k = (j == 0) ? 24'h0 : 24'($random(seed));
            fen = (j == 0) ? 1'b0 : 1'($random(seed));
            pre = (j == 0) ? 2'h1 : 2'($random(seed));
            dc = (j == 0) ? 3'h2 : 3'($random(seed));
            opd = 2'($random(seed));
            src = (j != 1);
            on = (j != 8);
            ref_half <= 16'd66 + 16'($random(seed) & 63);
            axi_write(8'h04, on ? 32'h21 : 32'h20, rs);
            axi_write(8'h90, {25'h0, fen, pre, 4'(n)}, rs);
            axi_write(8'h94, {26'h0, k[23:18]}, rs);
            axi_write(8'h98, {23'h0, k[17:9]}, rs);
            axi_write(8'h9C, {23'h0, k[8:0]}, rs);
            axi_write(8'h18, {23'h0, src, dc, 5'h0}, rs);
            axi_write(8'h20, {26'h0, opd, 1'b0, on, 2'b00}, rs);
            repeat (1600) @(posedge aclk);
            // Window opens and closes at the same phase after a reference edge
            @(posedge ref_clk);
            @(posedge aclk);
            n_tick = 0;
            n_pin = 0;
            n_clk = 0;
            n_ref = 0;
            win = 1'b1;
            wait (n_ref == 64);
            @(posedge aclk);
            win = 1'b0;
            post4 = on ? n_ref * (n + (fen ? k / 16777216.0 : 0.0)) * (8 >> pre) / 16.0 : 0.0;
            exp_t = (src ? post4 : n_ref) * 2.0 / dx2[dc];
            check("system ticks", n_tick, $rtoi(exp_t + 0.5), 2);
            check("system clock toggles", n_clk, $rtoi(exp_t + 0.5), 2);
            check("pin toggles", n_pin, $rtoi(post4 / (opd + 1) + 0.5), 2);
            check("pin enable", {31'h0, pin_oe_n}, !on, 0);
            check("synth running", {31'h0, active}, on, 0);
        end
        give_verdict;
    end
endmodule // testbench
